// *** inc/dctx_pkg.sv ***
// Constants shared by the connectivity test block
package dctx_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_PS = 40000;
	localparam int CLOCK_INPUT_VALID_TIME_PS = 20000;
	localparam int INPUT_ENABLE_INTERVAL_PS = 100000;
	localparam int OUTPUT_VALID_INTERVAL_PS = 40000;
	// Least times round up, never below one cycle
	localparam int CLOCK_VALID_CYCLES_RAW = (CLOCK_INPUT_VALID_TIME_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int CLOCK_VALID_CYCLES = (CLOCK_VALID_CYCLES_RAW < 1) ? 1 : CLOCK_VALID_CYCLES_RAW;
	localparam int INPUT_ENABLE_CYCLES_RAW = (INPUT_ENABLE_INTERVAL_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int INPUT_ENABLE_CYCLES = (INPUT_ENABLE_CYCLES_RAW < 1) ? 1 : INPUT_ENABLE_CYCLES_RAW;
	localparam int ENTRY_COUNT_WIDTH = 8;
	// ----------------------------------------
	// Pin counts and reset values
	// ----------------------------------------
	localparam int ADDR_WIDTH = 18;
	localparam int DQ_WIDTH = 16;
	localparam int TERM_COUNT = 10;
	localparam logic [7:0] ENTRY_COUNT_RESET = 8'h00;
	localparam logic ARRAY_UNDEFINED_RESET = 1'b0;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		DCTX_IDLE,
		DCTX_ENTRY,
		DCTX_ACTIVE
	} dctx_state_t;
endpackage : dctx_pkg

// *** logic/dctx_xor_term.sv ***
// One exclusive-OR minimum term over a small group of test inputs
`timescale 1ns/1ps
module dctx_xor_term #(
	parameter int WIDTH = 3
) (
	input wire logic [WIDTH-1:0] group_in,
	output logic term_out
);
	// Pure reduction, no storage on the test path
	assign term_out = ^group_in;
endmodule : dctx_xor_term

// *** logic/dctx_xor_top.sv ***
// Connectivity test mode: exclusive-OR network from test inputs to data and strobe pins
`timescale 1ns/1ps
module dctx_xor_top #(
	parameter bit TERM2_USES_A17 = 1'b1
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic conn_test_enable_in,
	input wire logic chip_select_n_in,
	input wire logic dev_reset_n_in,
	input wire logic x16_config_in,
	input wire logic [dctx_pkg::ADDR_WIDTH-1:0] addr_in,
	input wire logic [1:0] bank_in,
	input wire logic [1:0] bank_group_in,
	input wire logic clock_enable_in,
	input wire logic activate_n_in,
	input wire logic odt_in,
	input wire logic ck_true_in,
	input wire logic ck_comp_in,
	input wire logic parity_in,
	input wire logic alert_n_in,
	input wire logic mask_lower_n_in,
	input wire logic mask_upper_n_in,
	output logic [dctx_pkg::DQ_WIDTH-1:0] dq_out,
	output logic [dctx_pkg::DQ_WIDTH-1:0] dq_oe_out,
	output logic lower_strobe_t_out,
	output logic lower_strobe_c_out,
	output logic upper_strobe_t_out,
	output logic upper_strobe_c_out,
	output logic strobe_oe_out,
	output logic continuity_check_mode_out,
	output logic array_undefined_out
);
	// ----------------------------------------
	// Entry sequencer
	// ----------------------------------------
	dctx_pkg::dctx_state_t state;
	dctx_pkg::dctx_state_t next_state;
	logic [dctx_pkg::ENTRY_COUNT_WIDTH-1:0] entry_count;
	logic clocks_live;
	logic entry_allowed;
	logic entry_done;
	logic drive_enable;

	// Entry only with reset, cke and select all high
	assign entry_allowed = conn_test_enable_in && dev_reset_n_in && clock_enable_in && chip_select_n_in;
	assign entry_done = entry_count >= dctx_pkg::ENTRY_COUNT_WIDTH'(dctx_pkg::INPUT_ENABLE_CYCLES - 1);

	always_comb begin
		next_state = state;
		case (state)
			dctx_pkg::DCTX_IDLE: begin
				if (entry_allowed) begin
					next_state = dctx_pkg::DCTX_ENTRY;
				end
			end
			dctx_pkg::DCTX_ENTRY: begin
				if (!conn_test_enable_in) begin
					next_state = dctx_pkg::DCTX_IDLE;
				end else if (entry_done && !chip_select_n_in) begin
					// Sampling starts only once select permits it
					next_state = dctx_pkg::DCTX_ACTIVE;
				end
			end
			dctx_pkg::DCTX_ACTIVE: begin
				if (!conn_test_enable_in) begin
					next_state = dctx_pkg::DCTX_IDLE;
				end
			end
			default: begin
				next_state = dctx_pkg::DCTX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= dctx_pkg::DCTX_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Saturating count of cycles since entry
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			entry_count <= dctx_pkg::ENTRY_COUNT_RESET;
		end else if (state == dctx_pkg::DCTX_IDLE) begin
			entry_count <= dctx_pkg::ENTRY_COUNT_RESET;
		end else if (entry_count != {dctx_pkg::ENTRY_COUNT_WIDTH{1'b1}}) begin
			entry_count <= entry_count + 8'h01;
		end
	end

	// Clock pins become test inputs after the clock-input-valid time
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clocks_live <= 1'b0;
		end else if (state == dctx_pkg::DCTX_IDLE) begin
			clocks_live <= 1'b0;
		end else if (entry_count >= dctx_pkg::ENTRY_COUNT_WIDTH'(dctx_pkg::CLOCK_VALID_CYCLES - 1)) begin
			clocks_live <= 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			continuity_check_mode_out <= 1'b0;
		end else begin
			continuity_check_mode_out <= (next_state == dctx_pkg::DCTX_ACTIVE);
		end
	end

	// Sticky until reset: leaving the test spoils the array
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			array_undefined_out <= dctx_pkg::ARRAY_UNDEFINED_RESET;
		end else if (state != dctx_pkg::DCTX_IDLE && !conn_test_enable_in) begin
			array_undefined_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Minimum terms
	// ----------------------------------------
	logic [dctx_pkg::TERM_COUNT-1:0] term;
	logic [3:0] term2_group;
	logic term7_first;

	assign term2_group = {addr_in[2], addr_in[5], addr_in[13], addr_in[17] & TERM2_USES_A17};
	assign term7_first = x16_config_in ? mask_upper_n_in : bank_group_in[1];

	dctx_xor_term #(.WIDTH(3)) u_xor_term_zero (.group_in({addr_in[1], addr_in[6], parity_in}),
		.term_out(term[0]));
	dctx_xor_term #(.WIDTH(3)) u_term1 (.group_in({addr_in[8], alert_n_in, addr_in[9]}), .term_out(term[1]));
	dctx_xor_term #(.WIDTH(4)) u_term2 (.group_in(term2_group), .term_out(term[2]));
	dctx_xor_term #(.WIDTH(3)) u_term3 (.group_in({addr_in[0], addr_in[7], addr_in[11]}), .term_out(term[3]));
	dctx_xor_term #(.WIDTH(3)) u_term4 (.group_in({ck_comp_in, odt_in, addr_in[15]}), .term_out(term[4]));
	dctx_xor_term #(.WIDTH(3)) u_term5 (.group_in({clock_enable_in, addr_in[16], addr_in[10]}), .term_out(term[5]));
	dctx_xor_term #(.WIDTH(3)) u_term6 (.group_in({activate_n_in, addr_in[4], bank_in[1]}), .term_out(term[6]));
	dctx_xor_term #(.WIDTH(3)) u_term7 (.group_in({term7_first, mask_lower_n_in, ck_true_in}), .term_out(term[7]));
	dctx_xor_term #(.WIDTH(3)) u_xor_term_eight (.group_in({addr_in[14], addr_in[12], bank_in[0]}),
		.term_out(term[8]));
	dctx_xor_term #(.WIDTH(3)) u_xor_term_nine (.group_in({bank_group_in[0], addr_in[3],
		dev_reset_n_in & conn_test_enable_in}), .term_out(term[9]));

	// ----------------------------------------
	// Output network
	// ----------------------------------------
	// Combinational on purpose: the pins must follow inputs with no clock in the path
	assign dq_out = {~term[7:0], term[7:0]};
	assign lower_strobe_t_out = term[8];
	assign lower_strobe_c_out = term[9];
	assign upper_strobe_t_out = ~term[8];
	assign upper_strobe_c_out = ~term[9];

	// Enables follow select at once, so settling is within one gate delay
	assign drive_enable = (state == dctx_pkg::DCTX_ACTIVE) && clocks_live && conn_test_enable_in
		&& !chip_select_n_in;
	assign dq_oe_out = {{8{drive_enable && x16_config_in}}, {8{drive_enable}}};
	assign strobe_oe_out = drive_enable;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_x8_term0_map: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		dq_oe_out[0] |-> dq_out[0] == (addr_in[1] ^ addr_in[6] ^ parity_in))
		else $error("Data bit 0 does not follow its term");
	a_strobe_term_map: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		strobe_oe_out |-> lower_strobe_t_out == (addr_in[14] ^ addr_in[12] ^ bank_in[0]))
		else $error("True strobe does not follow term eight");
	a_upper_inverted: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		dq_oe_out[8] |-> dq_out[15:8] == ~dq_out[7:0] && upper_strobe_c_out != lower_strobe_c_out)
		else $error("Upper lane not inverted from lower lane");
	a_x8_upper_quiet: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!x16_config_in |-> dq_oe_out[15:8] == 8'h00)
		else $error("Upper lane driven in x8");
	a_clock_live_delay: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		$rose(entry_allowed) && state == dctx_pkg::DCTX_IDLE ##1 conn_test_enable_in [*2] |-> clocks_live)
		else $error("Clock pins not live in time");
	a_input_enable_wait: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state == dctx_pkg::DCTX_IDLE ##1 state == dctx_pkg::DCTX_ENTRY |-> !strobe_oe_out [*3])
		else $error("Outputs driven before input-enable interval");
	a_exit_undefined: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state == dctx_pkg::DCTX_ACTIVE && !conn_test_enable_in |=> array_undefined_out && !continuity_check_mode_out)
		else $error("Exit did not mark array undefined");
	a_select_floats: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		chip_select_n_in || !conn_test_enable_in |-> dq_oe_out == 16'h0000 && !strobe_oe_out)
		else $error("Outputs driven while deselected or out of test");
	a_output_settle: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		continuity_check_mode_out && conn_test_enable_in && !chip_select_n_in |-> strobe_oe_out
		&& lower_strobe_c_out == (bank_group_in[0] ^ addr_in[3] ^ dev_reset_n_in))
		else $error("Outputs not valid during active test");
	a_entry_refused: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state == dctx_pkg::DCTX_IDLE && !chip_select_n_in |=> state == dctx_pkg::DCTX_IDLE)
		else $error("Entry taken while select was low");
	a_upper_strobe_t: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		dq_oe_out[8] |-> upper_strobe_t_out == !(addr_in[14] ^ addr_in[12] ^ bank_in[0]))
		else $error("Upper true strobe not inverted");
	a_term7_upper: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		dq_oe_out[15] |-> dq_out[7] == (mask_upper_n_in ^ mask_lower_n_in ^ ck_true_in))
		else $error("Term seven ignores upper mask in x16");
	a_mode_needs_enable: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!conn_test_enable_in |=> !continuity_check_mode_out)
		else $error("Test mode shown without test enable");
endmodule : dctx_xor_top

// *** testbench/dctx_agent_model.sv ***
// Test agent model that drives the connectivity pins
`timescale 1ns/1ps
module dctx_agent_model (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [30:0] pat_in,
	input wire logic enable_req_in,
	input wire logic cs_n_req_in,
	output logic test_en_out,
	output logic cs_n_out,
	output logic dev_reset_n_out,
	output logic [30:0] pins_out
);
	logic powered;
	// Pins move on the falling edge, away from the sampling edge
	always_ff @(negedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			powered <= 1'b0;
			test_en_out <= 1'b0;
			cs_n_out <= 1'b1;
			pins_out <= 31'h0040_0000;
		end else begin
			powered <= 1'b1;
			test_en_out <= enable_req_in & powered & dev_reset_n_out;
			cs_n_out <= cs_n_req_in;
			pins_out <= pat_in;
		end
	end
	// Reset pin stays high; no refresh command exists in this model
	assign dev_reset_n_out = 1'b1;
	// Exit is always followed by a full reset from the bench
endmodule : dctx_agent_model

// *** testbench/tb_dctx_xor_top.sv ***
// Self-checking bench for the connectivity test block
`timescale 1ns/1ps
module tb_dctx_xor_top;
	logic clk = 1'b0, rst_n = 1'b0, enable_req = 1'b0, cs_req_n = 1'b1, x16 = 1'b0;
	logic [30:0] pat = 31'h0040_0000;
	logic test_en, cs_n, drst_n, lt, lc, ut, uc, s_oe, mode, undef;
	logic [30:0] p;
	logic [15:0] dq, oe;
	int error_cnt = 0, n_tests = 0, cycles = 0;
	dctx_agent_model agent (.clock_in(clk), .arst_n_in(rst_n), .pat_in(pat), .enable_req_in(enable_req),
		.cs_n_req_in(cs_req_n), .test_en_out(test_en), .cs_n_out(cs_n), .dev_reset_n_out(drst_n), .pins_out(p));
	dctx_xor_top dut (.clock_in(clk), .arst_n_in(rst_n), .conn_test_enable_in(test_en), .chip_select_n_in(cs_n),
		.dev_reset_n_in(drst_n), .x16_config_in(x16), .addr_in(p[17:0]), .bank_in(p[19:18]),
		.bank_group_in(p[21:20]), .clock_enable_in(p[22]), .activate_n_in(p[23]), .odt_in(p[24]),
		.ck_true_in(p[25]), .ck_comp_in(p[26]), .parity_in(p[27]), .alert_n_in(p[28]),
		.mask_lower_n_in(p[29]), .mask_upper_n_in(p[30]), .dq_out(dq), .dq_oe_out(oe),
		.lower_strobe_t_out(lt), .lower_strobe_c_out(lc), .upper_strobe_t_out(ut),
		.upper_strobe_c_out(uc), .strobe_oe_out(s_oe), .continuity_check_mode_out(mode),
		.array_undefined_out(undef));
	// ----------------------------------------
	// Clock, timeout and shared checks
	// ----------------------------------------
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	function automatic logic [9:0] terms(input logic [30:0] q, input logic w);
		logic [9:0] t;
		t[0] = q[1] ^ q[6] ^ q[27];
		t[1] = q[8] ^ q[28] ^ q[9];
		t[2] = q[2] ^ q[5] ^ q[13] ^ q[17];
		t[3] = q[0] ^ q[7] ^ q[11];
		t[4] = q[26] ^ q[24] ^ q[15];
		t[5] = q[22] ^ q[16] ^ q[10];
		t[6] = q[23] ^ q[4] ^ q[19];
		t[7] = (w ? q[30] : q[21]) ^ q[29] ^ q[25];
		t[8] = q[14] ^ q[12] ^ q[18];
		t[9] = ~(q[20] ^ q[3]);
		return t;
	endfunction : terms
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
		#5;
	endtask : cyc
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_refused;
		cs_req_n = 1'b0;
		enable_req = 1'b1;
		cyc(8);
		chk({15'h0000, mode}, 16'h0000, "entry with select low");
		chk(oe, 16'h0000, "enable while idle");
		enable_req = 1'b0;
		cs_req_n = 1'b1;
		cyc(2);
	endtask : t_refused
	task automatic t_enter;
		enable_req = 1'b1;
		cyc(6);
		chk({15'h0000, mode}, 16'h0000, "active before select");
		cs_req_n = 1'b0;
		cyc(2);
		chk({15'h0000, mode}, 16'h0001, "mode after entry");
	endtask : t_enter
	task automatic t_walk(input logic w);
		logic [9:0] t;
		@(negedge clk);
		x16 = w;
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			pat = 31'h0000_0001 << i;
			cyc(1);
			t = terms(pat, w);
			chk(w ? dq : {8'h00, dq[7:0]}, {w ? ~t[7:0] : 8'h00, t[7:0]}, "data");
			chk({12'h000, lt, lc, w ? {ut, uc} : 2'b00}, {12'h000, t[8], t[9], w ? ~t[8] : 1'b0,
				w ? ~t[9] : 1'b0}, "strobes");
			chk(oe, w ? 16'hffff : 16'h00ff, "data enable");
			chk({15'h0000, s_oe}, 16'h0001, "strobe enable");
		end
	endtask : t_walk
	task automatic t_float;
		cs_req_n = 1'b1;
		cyc(1);
		chk({oe[15:1], s_oe}, 16'h0000, "select high floats");
		cs_req_n = 1'b0;
		cyc(2);
		chk(oe, 16'hffff, "select low drives");
	endtask : t_float
	task automatic t_exit;
		enable_req = 1'b0;
		cyc(1);
		chk({oe[15:1], s_oe}, 16'h0000, "drive after exit");
		cyc(1);
		chk({14'h0000, mode, undef}, 16'h0001, "state after exit");
		rst_n = 1'b0;
		cyc(3);
		rst_n = 1'b1;
		chk({14'h0000, mode, undef}, 16'h0000, "after full reset");
	endtask : t_exit
	initial begin
		cyc(3);
		rst_n = 1'b1;
		t_refused();
		t_enter();
		t_walk(1'b0);
		t_walk(1'b1);
		t_float();
		t_exit();
		close_out();
	end
endmodule : tb_dctx_xor_top
